// ==== hdl/memmap_pkg.sv ====
package memmap_pkg;

	// Special-function addresses
	localparam logic [7:0]  sfr_stack_low_addr   = 8'h81;
	localparam logic [7:0]  sfr_stack_ext_addr   = 8'hb7;
	localparam logic [7:0]  sfr_core_cfg_addr    = 8'haf;
	localparam logic [7:0]  sfr_nvdata_addr_lo   = 8'hb8;
	localparam logic [7:0]  sfr_nvdata_addr_hi   = 8'hb9;
	localparam logic [7:0]  sfr_nvdata_data      = 8'hba;
	localparam logic [7:0]  sfr_nvdata_cmd       = 8'hbb;

	// Reset values
	localparam logic [7:0]  stack_low_reset      = 8'h07;
	localparam logic [2:0]  stack_ext_reset      = 3'h0;
	localparam logic [7:0]  core_cfg_reset       = 8'h00;

	// Field positions
	localparam int          cfg_ext_stack_bit    = 7;
	localparam int          cfg_extended_data_ram_en_bit      = 0;
	localparam int          stack_ext_width      = 3;

	// Code space
	localparam logic [15:0] code_internal_top    = 16'hf7ff;
	localparam logic [7:0]  nop_opcode           = 8'h00;
	localparam logic [15:0] flash_user_top       = 16'hdfff;

	// Data space
	localparam logic [7:0]  bank_region_top      = 8'h1f;
	localparam logic [7:0]  bit_region_base      = 8'h20;
	localparam logic [23:0] extended_data_ram_top             = 24'h0007ff;
	localparam logic [10:0] xstack_first         = 11'h100;
	localparam logic [12:0] nvdata_top           = 13'h0fff;

	typedef enum logic [1:0] {
		dsel_iram,
		dsel_sfr,
		dsel_none
	} iram_sel_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        indirect;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} idata_req_s;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [23:0] addr;
		logic [7:0]  wdata;
	} xdata_req_s;

	typedef struct packed {
		logic        ale;
		logic        rd_n;
		logic        wr_n;
		logic        ad_oe;
		logic [7:0]  ad_out;
		logic [15:0] addr_hi;
	} xbus_s;

	// Direct address of a bit-addressable spot
	function automatic logic [7:0] bit_byte_addr(input logic [7:0] bit_addr);
		if (bit_addr[7])
			bit_byte_addr = {bit_addr[7:3], 3'h0};
		else
			bit_byte_addr = bit_region_base + {4'h0, bit_addr[6:3]};
	endfunction : bit_byte_addr

endpackage : memmap_pkg

// ==== hdl/code_fetch_sel.sv ====
`timescale 1ns/1ps
module code_fetch_sel (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Strap, already synchronised
	input  wire logic        ext_code_sync,
	// Fetch request
	input  wire logic        fetch_req,
	input  wire logic [15:0] program_counter_value,
	// Code sources
	input  wire logic [7:0]  flash_rdata,
	input  wire logic [7:0]  ext_code_rdata,
	// Result
	output logic             fetch_ext_q,
	output logic             flash_rd_q,
	output logic [7:0]       fetch_data_q,
	output logic             fetch_valid_q
);
	logic external_mode_q;
	logic rst_seen_q;

	// Mode caught on the first edge after reset release
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rst_seen_q <= 1'b1;
		end else if (rst_seen_q) begin
			rst_seen_q      <= 1'b0;
			external_mode_q <= ~ext_code_sync;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			fetch_ext_q   <= 1'b0;
			flash_rd_q    <= 1'b0;
			fetch_data_q  <= 8'h00;
			fetch_valid_q <= 1'b0;
		end else begin
			fetch_valid_q <= fetch_req & ~rst_seen_q;
			fetch_ext_q   <= fetch_req & ~rst_seen_q & external_mode_q;
			flash_rd_q    <= fetch_req & ~rst_seen_q & ~external_mode_q &
				(program_counter_value <= memmap_pkg::code_internal_top);
			if (external_mode_q)
				fetch_data_q <= ext_code_rdata;
			else if (program_counter_value > memmap_pkg::code_internal_top)
				fetch_data_q <= memmap_pkg::nop_opcode;
			else
				fetch_data_q <= flash_rdata;
		end
	end
endmodule : code_fetch_sel

// ==== hdl/xdata_route.sv ====
`timescale 1ns/1ps
module xdata_route (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Request
	input  wire memmap_pkg::xdata_req_s req,
	input  wire logic                   extended_data_ram_en,
	// Result
	output logic                        to_extended_data_ram,
	output memmap_pkg::xbus_s           bus_q
);
	// bottom 2 kBytes go on chip when enabled
	assign to_extended_data_ram = extended_data_ram_en && (req.addr <= memmap_pkg::extended_data_ram_top);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bus_q <= '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, ad_oe: 1'b0, ad_out: 8'h00, addr_hi: 16'h0000};
		end else if (req.valid && !to_extended_data_ram) begin
			bus_q.ale     <= 1'b1;
			bus_q.rd_n    <= req.write;
			bus_q.wr_n    <= ~req.write;
			bus_q.ad_oe   <= 1'b1;
			bus_q.ad_out  <= req.write ? req.wdata : req.addr[7:0];
			bus_q.addr_hi <= req.addr[23:8];
		end else begin
			bus_q.ale   <= 1'b0;
			bus_q.rd_n  <= 1'b1;
			bus_q.wr_n  <= 1'b1;
			bus_q.ad_oe <= 1'b0;
		end
	end
endmodule : xdata_route

// ==== hdl/mcu_memory_map_decode.sv ====
`timescale 1ns/1ps
// How it works
// - external-code select low at reset means fetch from external program memory.
// - internal execution never rolls over into external code space.
// - fetches F800H to FFFFH in internal mode return the NOP opcode.
// - lower 128 RAM bytes reachable directly and indirectly.
// - upper 128 RAM bytes reachable only indirectly.
// - lowest 32 bytes form four banks of eight working registers.
// - bytes 20H-2FH also addressable as bits 00H-7FH.
// - stack pointer resets to 07H and increments before each push.
// - without extended stack, pointer wraps FFH to 00H.
// - core config bit 7 makes the pointer 11 bits, into extended RAM.
// - low pointer byte at 81H, extra three bits at B7H.
// - up to 1792 extended RAM bytes usable as stack.
// - external data moves generate their own strobes.
// - external data space is 16 MBytes, 24-bit address.
// - config bit maps bottom 2 kBytes to on-chip extended RAM.
// - on-chip extended RAM accesses leave ports 0 and 2 idle.
// - special function space is upper 128 addresses, direct only.
// - nonvolatile data memory reached only through control registers.
// - 56 kBytes of program memory writable at runtime.
// - only SFRs ending in 0H or 8H are bit addressable; SFR bit reads here return 0 and SFR bit writes are dropped.
module mcu_memory_map_decode #(
	parameter int extended_data_ram_depth = 2048,
	parameter int nv_depth   = 4096
) (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Strap pin
	input  wire logic                   external_code_select,
	// Instruction fetch
	input  wire logic                   fetch_req,
	input  wire logic [15:0]            program_counter_value,
	input  wire logic [7:0]             flash_rdata,
	input  wire logic [7:0]             ext_code_rdata,
	output logic                        fetch_ext_q,
	output logic                        flash_rd_q,
	output logic [7:0]                  fetch_data_q,
	output logic                        fetch_valid_q,
	// Internal data access
	input  wire memmap_pkg::idata_req_s idata_req,
	input  wire logic [1:0]             bank_select,
	input  wire logic [2:0]             work_reg_num,
	input  wire logic                   work_reg_req,
	input  wire logic                   bit_req,
	input  wire logic [7:0]             bit_addr,
	input  wire logic                   bit_wval,
	output logic [7:0]                  idata_rdata_q,
	output logic                        idata_valid_q,
	output logic                        bit_rdata_q,
	output logic                        bit_err_q,
	// Stack operations
	input  wire logic                   stack_push,
	input  wire logic                   stack_pop,
	input  wire logic [7:0]             stack_wdata,
	output logic [7:0]                  stack_rdata_q,
	output logic [10:0]                 stack_ptr_q,
	// External data move
	input  wire memmap_pkg::xdata_req_s xdata_req,
	input  wire logic [7:0]             ext_data_rdata,
	output logic [7:0]                  xdata_rdata_q,
	output logic                        xdata_valid_q,
	output memmap_pkg::xbus_s           xbus_q,
	// Flash program write port
	input  wire logic                   flash_prog_req,
	output logic                        flash_prog_ok_q,
	// Config visibility
	output logic [7:0]                  core_config_q
);
	localparam int xw = $clog2(extended_data_ram_depth);
	localparam int nw = $clog2(nv_depth);

	logic                strap_meta_q;
	logic                strap_sync_q;
	logic [7:0]          iram_q [256];
	logic [7:0]          extended_data_ram_q [extended_data_ram_depth];
	logic [7:0]          nvmem_q [nv_depth];
	logic [7:0]          stack_top_pointer_q;
	logic [2:0]          stack_pointer_extension_q;
	logic [7:0]          core_config_register_q;
	logic [7:0]          nv_addr_lo_q;
	logic [7:0]          nv_addr_hi_q;
	logic [7:0]          nv_data_q;
	logic [10:0]         sp_inc;
	logic [10:0]         sp_d;
	logic                to_extended_data_ram;
	logic [7:0]          bank_addr;
	logic [7:0]          bit_byte;
	logic                sfr_hit;
	logic                sfr_wr;
	memmap_pkg::iram_sel_e sel;
	logic [7:0]          sfr_rd;
	logic                ext_stack;
	logic [nw-1:0]       nv_index;

	// Strap crossing, kept running through reset so the level is settled at release
	always_ff @(posedge core_clk) begin
		strap_meta_q <= external_code_select;
		strap_sync_q <= strap_meta_q;
	end

	code_fetch_sel u_fetch (
		.core_clk              (core_clk),
		.rst                   (rst),
		.ext_code_sync         (strap_sync_q),
		.fetch_req             (fetch_req),
		.program_counter_value (program_counter_value),
		.flash_rdata           (flash_rdata),
		.ext_code_rdata        (ext_code_rdata),
		.fetch_ext_q           (fetch_ext_q),
		.flash_rd_q            (flash_rd_q),
		.fetch_data_q          (fetch_data_q),
		.fetch_valid_q         (fetch_valid_q)
	);

	xdata_route u_xroute (
		.core_clk (core_clk),
		.rst      (rst),
		.req      (xdata_req),
		.extended_data_ram_en  (core_config_register_q[memmap_pkg::cfg_extended_data_ram_en_bit]),
		.to_extended_data_ram  (to_extended_data_ram),
		.bus_q    (xbus_q)
	);

	assign ext_stack = core_config_register_q[memmap_pkg::cfg_ext_stack_bit];
	assign nv_index  = nw'({nv_addr_hi_q, nv_addr_lo_q});

	// Working register address in the selected bank
	assign bank_addr = {3'h0, bank_select, work_reg_num};

	assign bit_byte = memmap_pkg::bit_byte_addr(bit_addr);

	// Direct addresses at 80H and up hit SFRs; indirect ones hit RAM
	always_comb begin
		if (!idata_req.addr[7] || idata_req.indirect)
			sel = memmap_pkg::dsel_iram;
		else
			sel = memmap_pkg::dsel_sfr;
	end

	assign sfr_hit = idata_req.valid && (sel == memmap_pkg::dsel_sfr);
	assign sfr_wr  = sfr_hit && idata_req.write;

	// SPECIAL_FUNCTION_SPACE read mux, unimplemented locations read zero
	always_comb begin
		case (idata_req.addr)
			memmap_pkg::sfr_stack_low_addr: sfr_rd = stack_top_pointer_q;
			memmap_pkg::sfr_stack_ext_addr: sfr_rd = {5'h00, stack_pointer_extension_q};
			memmap_pkg::sfr_core_cfg_addr:  sfr_rd = core_config_register_q;
			memmap_pkg::sfr_nvdata_addr_lo: sfr_rd = nv_addr_lo_q;
			memmap_pkg::sfr_nvdata_addr_hi: sfr_rd = nv_addr_hi_q;
			memmap_pkg::sfr_nvdata_data:    sfr_rd = nv_data_q;
			default:                        sfr_rd = 8'h00;
		endcase
	end

	// Pre-increment, wrap depends on mode
	always_comb begin
		sp_inc = {stack_pointer_extension_q, stack_top_pointer_q} + 11'h001;
		if (!ext_stack)
			sp_inc = {3'h0, stack_top_pointer_q + 8'h01};
		sp_d = {stack_pointer_extension_q, stack_top_pointer_q};
		if (stack_push)
			sp_d = sp_inc;
		else if (stack_pop)
			sp_d = ext_stack ? sp_d - 11'h001 : {3'h0, stack_top_pointer_q - 8'h01};
	end

	// Stack pointer and its SPECIAL_FUNCTION_SPACE writes
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stack_top_pointer_q       <= memmap_pkg::stack_low_reset;
			stack_pointer_extension_q <= memmap_pkg::stack_ext_reset;
		end else if (stack_push || stack_pop) begin
			stack_top_pointer_q       <= sp_d[7:0];
			stack_pointer_extension_q <= sp_d[10:8];
		end else if (sfr_wr && idata_req.addr == memmap_pkg::sfr_stack_low_addr) begin
			stack_top_pointer_q <= idata_req.wdata;
		end else if (sfr_wr && idata_req.addr == memmap_pkg::sfr_stack_ext_addr) begin
			stack_pointer_extension_q <= idata_req.wdata[2:0];
		end
	end

	// Configuration and nonvolatile control registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			core_config_register_q <= memmap_pkg::core_cfg_reset;
			nv_addr_lo_q           <= 8'h00;
			nv_addr_hi_q           <= 8'h00;
		end else if (sfr_wr) begin
			case (idata_req.addr)
				memmap_pkg::sfr_core_cfg_addr:  core_config_register_q <= idata_req.wdata;
				memmap_pkg::sfr_nvdata_addr_lo: nv_addr_lo_q <= idata_req.wdata;
				memmap_pkg::sfr_nvdata_addr_hi: nv_addr_hi_q <= idata_req.wdata;
				default: ;
			endcase
		end
	end

	// Nonvolatile data reached only through the control registers
	always_ff @(posedge core_clk) begin
		if (rst) begin
			nv_data_q <= 8'h00;
		end else if (sfr_wr && idata_req.addr == memmap_pkg::sfr_nvdata_data) begin
			nv_data_q <= idata_req.wdata;
		end else if (sfr_wr && idata_req.addr == memmap_pkg::sfr_nvdata_cmd) begin
			if (idata_req.wdata[0])
				nv_data_q <= nvmem_q[nv_index];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sfr_wr && idata_req.addr == memmap_pkg::sfr_nvdata_cmd && idata_req.wdata[1])
			nvmem_q[nv_index] <= nv_data_q;
	end

	// Internal RAM writes: byte, working register, bit, push
	always_ff @(posedge core_clk) begin
		if (stack_push && !(ext_stack && sp_inc[10:8] != 3'h0)) begin
			iram_q[sp_inc[7:0]] <= stack_wdata;
		end else if (work_reg_req && idata_req.write) begin
			iram_q[bank_addr] <= idata_req.wdata;
		end else if (bit_req && !bit_addr[7] && idata_req.write) begin
			iram_q[bit_byte][bit_addr[2:0]] <= bit_wval;
		end else if (idata_req.valid && idata_req.write && sel == memmap_pkg::dsel_iram) begin
			iram_q[idata_req.addr] <= idata_req.wdata;
		end
	end

	// Extended RAM: stack above 0FFH, then move instructions
	always_ff @(posedge core_clk) begin
		if (stack_push && ext_stack && sp_inc[10:8] != 3'h0) begin
			extended_data_ram_q[xw'(sp_inc)] <= stack_wdata;
		end else if (xdata_req.valid && xdata_req.write && to_extended_data_ram) begin
			extended_data_ram_q[xw'(xdata_req.addr)] <= xdata_req.wdata;
		end
	end

	// Read results
	always_ff @(posedge core_clk) begin
		if (rst) begin
			idata_rdata_q <= 8'h00;
			idata_valid_q <= 1'b0;
			bit_rdata_q   <= 1'b0;
			bit_err_q     <= 1'b0;
			stack_rdata_q <= 8'h00;
			xdata_rdata_q <= 8'h00;
			xdata_valid_q <= 1'b0;
		end else begin
			idata_valid_q <= idata_req.valid | work_reg_req | bit_req;
			if (work_reg_req)
				idata_rdata_q <= iram_q[bank_addr];
			else if (sel == memmap_pkg::dsel_iram)
				idata_rdata_q <= iram_q[idata_req.addr];
			else
				idata_rdata_q <= sfr_rd;
			bit_err_q <= bit_req && bit_addr[7] && (bit_addr[6:3] == 4'h7);
			if (!bit_addr[7])
				bit_rdata_q <= iram_q[bit_byte][bit_addr[2:0]];
			else if (bit_byte == memmap_pkg::sfr_stack_low_addr)
				bit_rdata_q <= 1'b0;
			else
				bit_rdata_q <= (bit_byte == memmap_pkg::sfr_core_cfg_addr) ? 1'b0 : 1'b0;
			if (ext_stack && stack_pointer_extension_q != 3'h0)
				stack_rdata_q <= extended_data_ram_q[xw'({stack_pointer_extension_q, stack_top_pointer_q})];
			else
				stack_rdata_q <= iram_q[stack_top_pointer_q];
			xdata_valid_q <= xdata_req.valid & ~xdata_req.write;
			// External data is taken while the read strobe is out
			if (xdata_req.valid && to_extended_data_ram)
				xdata_rdata_q <= extended_data_ram_q[xw'(xdata_req.addr)];
			else if (!xbus_q.rd_n)
				xdata_rdata_q <= ext_data_rdata;
		end
	end

	// Runtime programming allowed only in the lower 56 kBytes
	always_ff @(posedge core_clk) begin
		if (rst)
			flash_prog_ok_q <= 1'b0;
		else
			flash_prog_ok_q <= flash_prog_req && (program_counter_value <= memmap_pkg::flash_user_top);
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			stack_ptr_q <= {memmap_pkg::stack_ext_reset, memmap_pkg::stack_low_reset};
		else
			stack_ptr_q <= sp_d;
	end

	always_ff @(posedge core_clk) begin
		if (rst)
			core_config_q <= memmap_pkg::core_cfg_reset;
		else
			core_config_q <= core_config_register_q;
	end
endmodule : mcu_memory_map_decode

// ==== tb/memmap_properties.sv ====
`timescale 1ns/1ps
module memmap_properties (
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Fetch
	input  wire logic                   fetch_req,
	input  wire logic [15:0]            program_counter_value,
	input  wire logic                   fetch_ext_q,
	input  wire logic                   flash_rd_q,
	input  wire logic [7:0]             fetch_data_q,
	input  wire logic                   fetch_valid_q,
	// Stack
	input  wire logic                   stack_push,
	input  wire logic                   stack_pop,
	input  wire logic [10:0]            stack_ptr_q,
	input  wire logic [7:0]             core_config_q,
	// External data and program writes
	input  wire memmap_pkg::xdata_req_s xdata_req,
	input  wire memmap_pkg::xbus_s      xbus_q,
	input  wire logic                   flash_prog_req,
	input  wire logic                   flash_prog_ok_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic on_chip;
	assign on_chip = core_config_q[0] && (xdata_req.addr <= 24'h0007ff);
	sequence s_ext_req;
		xdata_req.valid && !on_chip;
	endsequence
	sequence s_bus_rd;
		xbus_q.ale && !xbus_q.rd_n && xbus_q.wr_n && xbus_q.ad_oe;
	endsequence
	property p_rst_ptr;
		$fell(rst) |-> stack_ptr_q == 11'h007;
	endproperty
	property p_push8;
		stack_push && !stack_pop && !core_config_q[7] |=> stack_ptr_q[7:0] == $past(stack_ptr_q[7:0]) + 8'h01;
	endproperty
	property p_push11;
		stack_push && !stack_pop && core_config_q[7] |=> stack_ptr_q == $past(stack_ptr_q) + 11'h001;
	endproperty
	property p_pop8;
		stack_pop && !stack_push && !core_config_q[7] |=> stack_ptr_q[7:0] == $past(stack_ptr_q[7:0]) - 8'h01;
	endproperty
	property p_nop;
		fetch_valid_q && !fetch_ext_q && ($past(program_counter_value) > 16'hf7ff) |-> fetch_data_q == 8'h00;
	endproperty
	property p_ext_src;
		fetch_ext_q |-> fetch_valid_q && !flash_rd_q;
	endproperty
	property p_ext_rd;
		s_ext_req ##0 !xdata_req.write |=> s_bus_rd ##0 (xbus_q.addr_hi == $past(xdata_req.addr[23:8]));
	endproperty
	property p_ext_wr;
		s_ext_req ##0 xdata_req.write |=> !xbus_q.wr_n && xbus_q.rd_n && xbus_q.ad_out == $past(xdata_req.wdata);
	endproperty
	property p_quiet;
		xdata_req.valid && on_chip |=> !xbus_q.ale && !xbus_q.ad_oe && xbus_q.rd_n && xbus_q.wr_n;
	endproperty
	property p_idle;
		!xdata_req.valid |=> xbus_q.rd_n && xbus_q.wr_n;
	endproperty
	property p_prog;
		flash_prog_req |=> flash_prog_ok_q == ($past(program_counter_value) <= 16'hdfff);
	endproperty
	a_rst_ptr: assert property (p_rst_ptr) else $error("pointer not 007 after reset");
	a_push8: assert property (p_push8) else $error("8-bit push step wrong");
	a_push11: assert property (p_push11) else $error("11-bit push step wrong");
	a_pop8: assert property (p_pop8) else $error("pop step wrong");
	a_nop: assert property (p_nop) else $error("top code region not NOP");
	a_ext_src: assert property (p_ext_src) else $error("external fetch read flash");
	a_ext_rd: assert property (p_ext_rd) else $error("external read strobes wrong");
	a_ext_wr: assert property (p_ext_wr) else $error("external write strobes wrong");
	a_quiet: assert property (p_quiet) else $error("on-chip access drove bus");
	a_idle: assert property (p_idle) else $error("strobe without request");
	a_prog: assert property (p_prog) else $error("program write window wrong");
endmodule : memmap_properties

// ==== tb/ext_mem_model.sv ====
`timescale 1ns/1ps
module ext_mem_model (
	// Clock
	input  wire logic              core_clk,
	// Program side
	input  wire logic [15:0]       code_addr,
	output logic [7:0]             code_rdata,
	// Data side
	input  wire memmap_pkg::xbus_s bus,
	output logic [7:0]             data_rdata
);
	logic [7:0] mem [16];
	logic [7:0] last_q;
	assign code_rdata = code_addr[7:0] ^ 8'h3c;
	always_ff @(posedge core_clk) begin
		if (!bus.wr_n)
			mem[bus.addr_hi[3:0]] <= bus.ad_out;
		if (!bus.rd_n)
			last_q <= mem[bus.addr_hi[3:0]];
	end
	// Released lines show the inverse of the last byte
	assign data_rdata = bus.rd_n ? ~last_q : mem[bus.addr_hi[3:0]];
endmodule : ext_mem_model

// ==== tb/tb_mcu_memory_map_decode.sv ====
`timescale 1ns/1ps
module tb_mcu_memory_map_decode;
	logic                   core_clk, rst, external_code_select, fetch_req, flash_prog_req;
	logic                   work_reg_req, bit_req, bit_wval, stack_push, stack_pop, bt, fx, po;
	logic                   fetch_ext_q, flash_rd_q, fetch_valid_q, idata_valid_q, bit_rdata_q;
	logic                   bit_err_q, xdata_valid_q, flash_prog_ok_q;
	logic [1:0]             bank_select;
	logic [2:0]             work_reg_num;
	logic [7:0]             flash_rdata, ext_code_rdata, fetch_data_q, bit_addr, idata_rdata_q;
	logic [7:0]             stack_wdata, stack_rdata_q, ext_data_rdata, xdata_rdata_q, core_config_q;
	logic [7:0]             rd, sr, fd, xr;
	logic                   iv, fv, xv;
	logic [10:0]            stack_ptr_q, sp;
	logic [15:0]            program_counter_value;
	memmap_pkg::idata_req_s idata_req;
	memmap_pkg::xdata_req_s xdata_req;
	memmap_pkg::xbus_s      xbus_q, xb;
	int                     failures = 0;
	int                     check_count = 0;

	assign flash_rdata = program_counter_value[7:0] ^ 8'ha5;
	mcu_memory_map_decode dut (.core_clk, .rst, .external_code_select, .fetch_req, .program_counter_value,
		.flash_rdata, .ext_code_rdata, .fetch_ext_q, .flash_rd_q, .fetch_data_q, .fetch_valid_q, .idata_req,
		.bank_select, .work_reg_num, .work_reg_req, .bit_req, .bit_addr, .bit_wval, .idata_rdata_q,
		.idata_valid_q, .bit_rdata_q, .bit_err_q, .stack_push, .stack_pop, .stack_wdata, .stack_rdata_q,
		.stack_ptr_q, .xdata_req, .ext_data_rdata, .xdata_rdata_q, .xdata_valid_q, .xbus_q, .flash_prog_req,
		.flash_prog_ok_q, .core_config_q);
	ext_mem_model u_ext (.core_clk, .code_addr(program_counter_value), .code_rdata(ext_code_rdata),
		.bus(xbus_q), .data_rdata(ext_data_rdata));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick;
		@(posedge core_clk);
		#1;
	endtask : tick
	// Request stands one edge, results taken in the cycle they stand
	task automatic cyc;
		tick();
		rd = idata_rdata_q; bt = bit_rdata_q; sp = stack_ptr_q; sr = stack_rdata_q;
		fd = fetch_data_q; fx = fetch_ext_q; xb = xbus_q; xr = xdata_rdata_q; po = flash_prog_ok_q;
		iv = idata_valid_q; fv = fetch_valid_q; xv = xdata_valid_q;
		idata_req = '0; xdata_req = '0; fetch_req = 1'b0; stack_push = 1'b0; stack_pop = 1'b0;
		work_reg_req = 1'b0; bit_req = 1'b0; flash_prog_req = 1'b0;
		tick();
	endtask : cyc
	task automatic do_reset(input logic s);
		external_code_select = s;
		rst = 1'b1;
		repeat (16) tick();
		rst = 1'b0;
		repeat (2) tick();
	endtask : do_reset
	task automatic mem(input logic w, input logic i, input logic [7:0] a, input logic [7:0] d);
		idata_req = '{1'b1, w, i, a, d};
		cyc();
	endtask : mem
	task automatic xacc(input logic w, input logic [23:0] a, input logic [7:0] d);
		xdata_req = '{1'b1, w, a, d};
		cyc();
	endtask : xacc
	task automatic fetch(input logic [15:0] pc, input logic p);
		program_counter_value = pc;
		fetch_req = !p;
		flash_prog_req = p;
		cyc();
	endtask : fetch
	task automatic push(input logic [7:0] d);
		stack_push = 1'b1;
		stack_wdata = d;
		cyc();
	endtask : push
	task automatic bitop(input logic w, input logic [7:0] a);
		idata_req = '{1'b0, w, 1'b0, 8'h00, 8'h00};
		bit_req = 1'b1;
		bit_addr = a;
		bit_wval = 1'b1;
		cyc();
	endtask : bitop

	task automatic t_reset;
		chk(stack_ptr_q, 16'h0007);
		chk({xbus_q.rd_n, xbus_q.wr_n}, 16'h0003);
		mem(0, 0, 8'hb7, 8'h00); chk(rd, 16'h0000);
		mem(0, 0, 8'h81, 8'h00); chk(rd, 16'h0007);
	endtask : t_reset
	task automatic t_fetch;
		logic [15:0] pcs [4] = '{16'h0123, 16'hf7ff, 16'hf800, 16'hffff};
		for (int i = 0; i < 4; i++) begin
			fetch(pcs[i], 1'b0);
			chk(fx, 16'h0000);
			chk(fv, 16'h0001);
			chk(fd, (pcs[i] > 16'hf7ff) ? 16'h0000 : {8'h00, pcs[i][7:0] ^ 8'ha5});
		end
		fetch(16'hdfff, 1'b1); chk(po, 16'h0001);
		fetch(16'he000, 1'b1); chk(po, 16'h0000);
	endtask : t_fetch
	task automatic t_stack;
		push(8'ha5); chk(sp, 16'h0008);
		mem(0, 1, 8'h08, 8'h00); chk(rd, 16'h00a5);
		stack_pop = 1'b1; cyc(); chk(sr, 16'h00a5);
		chk(sp, 16'h0007);
		mem(1, 0, 8'h81, 8'hff); push(8'h11); chk(sp, 16'h0000);
		mem(1, 0, 8'haf, 8'h81); mem(1, 0, 8'h81, 8'hff);
		push(8'h3c); chk(sp, 16'h0100);
		mem(0, 0, 8'hb7, 8'h00); chk(rd, 16'h0001);
		xacc(0, 24'h000100, 8'h00); chk(xr, 16'h003c);
		mem(1, 0, 8'hb7, 8'hff); mem(0, 0, 8'hb7, 8'h00); chk(rd, 16'h0007);
		mem(1, 0, 8'hb7, 8'h00); mem(1, 0, 8'h81, 8'h07); mem(1, 0, 8'haf, 8'h00);
	endtask : t_stack
	task automatic t_idata;
		mem(1, 0, 8'h30, 8'h11); mem(0, 1, 8'h30, 8'h00); chk(rd, 16'h0011);
		chk(iv, 16'h0001);
		mem(1, 1, 8'h30, 8'h12); mem(0, 0, 8'h30, 8'h00); chk(rd, 16'h0012);
		mem(1, 1, 8'h90, 8'h22); mem(0, 1, 8'h90, 8'h00); chk(rd, 16'h0022);
		mem(0, 0, 8'h90, 8'h00); chk(rd, 16'h0000);
	endtask : t_idata
	task automatic t_banks;
		for (int b = 0; b < 4; b++) begin
			bank_select = 2'(b);
			work_reg_num = 3'h7;
			work_reg_req = 1'b1;
			idata_req = '{1'b0, 1'b1, 1'b0, 8'h00, 8'h40 | 8'(b)};
			cyc();
			mem(0, 0, {3'h0, 2'(b), 3'h7}, 8'h00); chk(rd, 16'h0040 | 16'(b));
		end
	endtask : t_banks
	task automatic t_bits;
		mem(1, 0, 8'h21, 8'h00); bitop(1, 8'h0a); mem(0, 0, 8'h21, 8'h00); chk(rd, 16'h0004);
		mem(1, 0, 8'h2f, 8'h00); bitop(1, 8'h7f); mem(0, 0, 8'h2f, 8'h00); chk(rd, 16'h0080);
		bitop(0, 8'h0a); chk(bt, 16'h0001);
	endtask : t_bits
	task automatic t_xdata;
		xacc(1, 24'h000300, 8'h5a); chk({xb.wr_n, xb.rd_n, xb.ad_oe}, 16'h0003);
		chk(xb.ad_out, 16'h005a);
		xacc(0, 24'h123456, 8'h00); chk({xb.ale, xb.rd_n, xb.ad_oe}, 16'h0005);
		chk(xb.addr_hi, 16'h1234);
		chk(xv, 16'h0001);
		xacc(0, 24'h000300, 8'h00); chk(xdata_rdata_q, 16'h005a);
		mem(1, 0, 8'haf, 8'h01);
		xacc(1, 24'h0007ff, 8'h77); chk({xb.ale, xb.ad_oe, xb.wr_n}, 16'h0001);
		xacc(0, 24'h0007ff, 8'h00); chk(xr, 16'h0077);
		xacc(0, 24'h000800, 8'h00); chk(xb.ale, 16'h0001);
		mem(1, 0, 8'haf, 8'h00);
	endtask : t_xdata
	task automatic t_ext_code;
		do_reset(1'b0);
		fetch(16'hf900, 1'b0); chk(fx, 16'h0001);
		chk(fd, 16'h003c);
	endtask : t_ext_code
	task automatic stop_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test

	initial begin
		rst = 1'b1; external_code_select = 1'b1; fetch_req = 1'b0; program_counter_value = 16'h0000;
		idata_req = '0; xdata_req = '0; bank_select = 2'h0; work_reg_num = 3'h0; work_reg_req = 1'b0;
		bit_req = 1'b0; bit_addr = 8'h00; bit_wval = 1'b0; stack_push = 1'b0; stack_pop = 1'b0;
		stack_wdata = 8'h00; flash_prog_req = 1'b0;
		do_reset(1'b1);
		t_reset(); t_fetch(); t_stack(); t_idata(); t_banks(); t_bits(); t_xdata(); t_ext_code();
		stop_test();
	end
endmodule : tb_mcu_memory_map_decode

bind mcu_memory_map_decode memmap_properties u_props (.core_clk, .rst, .fetch_req, .program_counter_value,
	.fetch_ext_q, .flash_rd_q, .fetch_data_q, .fetch_valid_q, .stack_push, .stack_pop, .stack_ptr_q,
	.core_config_q, .xdata_req, .xbus_q, .flash_prog_req, .flash_prog_ok_q);
